// ==== ssd_pkg.sv ====
package ssd_pkg;

  // bus geometry
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SEL_W = DATA_W / 8;
  localparam int unsigned WORD_LSB = 2;

  // register byte addresses
  localparam logic [31:0] CH_SWITCH_ADDR = 32'h400c20e0;
  localparam logic [31:0] DAC_CODES_ADDR = 32'h400c2120;
  localparam logic [31:0] DAC_CTRL_ADDR = 32'h400c2128;

  // channel_switch_config layout
  localparam int unsigned SW_LSB = 0;
  localparam int unsigned SW_W = 14;
  localparam int unsigned BANK_W = 12;
  localparam int unsigned AMP_BIAS_BIT = 13;
  localparam int unsigned POT_BIAS_BIT = 12;
  localparam int unsigned FEEDBACK_BIT = 5;
  localparam logic [SW_W-1:0] SW_RESET = 14'h0000;

  // dac_output_codes layout
  localparam int unsigned FINE_LSB = 0;
  localparam int unsigned FINE_W = 12;
  localparam int unsigned COARSE_LSB = 12;
  localparam int unsigned COARSE_W = 6;
  localparam logic [FINE_W-1:0] FINE_RESET = 12'h000;
  localparam logic [COARSE_W-1:0] COARSE_RESET = 6'h00;

  // dac control layout (only the two selects are held here)
  localparam int unsigned ZERO_SEL_BIT = 4;
  localparam int unsigned SRC_SEL_BIT = 6;
  localparam logic [0:0] SEL_RESET = 1'h0;

  // zero-extension of the coarse code onto the zero-reference bus
  localparam int unsigned ZPAD_W = FINE_W - COARSE_W;
  localparam logic [ZPAD_W-1:0] ZPAD = 6'h00;

  localparam logic [DATA_W-1:0] RD_ZERO = 32'h00000000;

endpackage

// ==== ssd_field_reg.sv ====
`timescale 1ns/100ps
module ssd_field_reg #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned LSB = 0,
  parameter logic [WIDTH-1:0] RESET = '0
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset, high
  input wire logic wr_i, // write strobe for this register
  input wire logic [ssd_pkg::SEL_W-1:0] sel_i, // byte enables
  input wire logic [ssd_pkg::DATA_W-1:0] dat_i, // write data word
  output logic [WIDTH-1:0] q_o // held field value
);

  logic [WIDTH-1:0] next_q;

  // refuse at elaboration a field that would spill out of the bus word
  if (WIDTH < 1 || LSB + WIDTH > ssd_pkg::DATA_W)
  begin : g_fit_check
    $error("ssd_field_reg: field does not fit the data word");
  end

  // only lanes enabled by sel_i change; bits outside the field never stored
  always_comb
  begin
    next_q = q_o;
    if (rst_i)
      next_q = RESET;
    else if (wr_i)
      for (int i = 0; i < WIDTH; i++)
        if (sel_i[(LSB + i) / 8])
          next_q[i] = dat_i[LSB + i];
  end

  always_ff @(posedge clk_i)
    q_o <= next_q;

endmodule

// ==== ssd_regs.sv ====
`timescale 1ns/100ps
// How it works
// - switch register at fixed address, resets zero
// - bit 13 ties amp bias to zero pin
// - bit 12 ties pot bias to bias pin
// - bits 11..0 independent active-high switches
// - bit 5 closes feedback element switch
// - dac code register at fixed address, zero
// - 6-bit coarse code in bits 17..12
// - 12-bit fine code in bits 11..0
// - zero node takes fine code when selected
// - source select picks register or waveform codes
module ssd_regs #(
  parameter int unsigned ADDR_W = 32
) (
  input wire logic clk_i, // system clock, 40 MHz
  input wire logic rst_i, // sync reset, high
  input wire logic [ADDR_W-1:0] adr_i, // wishbone byte address
  input wire logic [ssd_pkg::DATA_W-1:0] dat_i, // wishbone write data
  output logic [ssd_pkg::DATA_W-1:0] dat_o, // wishbone read data
  input wire logic we_i, // wishbone write enable
  input wire logic [ssd_pkg::SEL_W-1:0] sel_i, // wishbone byte selects
  input wire logic cyc_i, // wishbone cycle
  input wire logic stb_i, // wishbone strobe
  output logic ack_o, // wishbone ack
  output logic err_o, // wishbone error, unmapped
  input wire logic [ssd_pkg::COARSE_W-1:0] wave_coarse_i, // wavegen 6-bit
  input wire logic [ssd_pkg::FINE_W-1:0] wave_fine_i, // wavegen 12-bit
  output logic amp_bias_to_zero_pin_o, // amp bias to zero pin
  output logic pot_bias_to_bias_pin_o, // pot bias to bias pin
  output logic feedback_element_switch_o, // feedback element switch
  output logic [ssd_pkg::BANK_W-1:0] switch_bank_o, // switches 11..0
  output logic [ssd_pkg::COARSE_W-1:0] coarse_code_o, // 6-bit dac code
  output logic [ssd_pkg::FINE_W-1:0] fine_code_o, // 12-bit dac code
  output logic [ssd_pkg::FINE_W-1:0] zero_reference_code_o, // zero node
  output logic zero_node_width_select_o // zero node uses fine code
);

  // decode compares bits 31..2 of full 32-bit byte addresses
  if (ADDR_W != 32)
  begin : g_addr_check
    $error("ssd_regs: address decode needs a 32-bit byte address");
  end

  logic [ssd_pkg::SW_W-1:0] sw_q;
  logic [ssd_pkg::FINE_W-1:0] fine_q;
  logic [ssd_pkg::COARSE_W-1:0] coarse_q;
  logic [0:0] zero_sel_q;
  logic [0:0] src_sel_q;

  logic hit_sw;
  logic hit_dac;
  logic hit_ctl;
  logic mapped;
  logic req_new;
  logic wr_sw;
  logic wr_dac;
  logic wr_ctl;
  logic [ssd_pkg::DATA_W-1:0] rd_word;

  logic next_ack;
  logic next_err;
  logic [ssd_pkg::DATA_W-1:0] next_dat;

  // address decode on whole words; low two bits left to sel_i
  always_comb
  begin
    hit_sw = adr_i[ADDR_W-1:ssd_pkg::WORD_LSB]
      == ssd_pkg::CH_SWITCH_ADDR[31:ssd_pkg::WORD_LSB];
    hit_dac = adr_i[ADDR_W-1:ssd_pkg::WORD_LSB]
      == ssd_pkg::DAC_CODES_ADDR[31:ssd_pkg::WORD_LSB];
    hit_ctl = adr_i[ADDR_W-1:ssd_pkg::WORD_LSB]
      == ssd_pkg::DAC_CTRL_ADDR[31:ssd_pkg::WORD_LSB];
    mapped = hit_sw | hit_dac | hit_ctl;
    // a new request is one not yet answered
    req_new = cyc_i & stb_i & ~ack_o & ~err_o;
    // writes land on the edge where the master sees ack, as it expects
    wr_sw = cyc_i & stb_i & we_i & ack_o & hit_sw;
    wr_dac = cyc_i & stb_i & we_i & ack_o & hit_dac;
    wr_ctl = cyc_i & stb_i & we_i & ack_o & hit_ctl;
  end

  // read word assembly; reserved bits stay zero
  always_comb
  begin
    rd_word = ssd_pkg::RD_ZERO;
    if (hit_sw)
      rd_word[ssd_pkg::SW_LSB +: ssd_pkg::SW_W] = sw_q;
    if (hit_dac)
    begin
      rd_word[ssd_pkg::FINE_LSB +: ssd_pkg::FINE_W] = fine_q;
      rd_word[ssd_pkg::COARSE_LSB +: ssd_pkg::COARSE_W] = coarse_q;
    end
    if (hit_ctl)
    begin
      rd_word[ssd_pkg::ZERO_SEL_BIT] = zero_sel_q[0];
      rd_word[ssd_pkg::SRC_SEL_BIT] = src_sel_q[0];
    end
  end

  // single-wait-state slave: answer one edge after the request is seen
  always_comb
  begin
    next_ack = 1'b0;
    next_err = 1'b0;
    next_dat = ssd_pkg::RD_ZERO;
    if (!rst_i && req_new)
    begin
      next_ack = mapped;
      next_err = ~mapped;
      if (mapped && !we_i)
        next_dat = rd_word;
    end
  end

  always_ff @(posedge clk_i)
  begin
    ack_o <= next_ack;
    err_o <= next_err;
    dat_o <= next_dat;
  end

  // 14 switch controls, reserved 31..14 never stored
  ssd_field_reg #(
    .WIDTH(ssd_pkg::SW_W),
    .LSB(ssd_pkg::SW_LSB),
    .RESET(ssd_pkg::SW_RESET)
  ) u_switch (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_sw),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .q_o(sw_q)
  );

  ssd_field_reg #(
    .WIDTH(ssd_pkg::FINE_W),
    .LSB(ssd_pkg::FINE_LSB),
    .RESET(ssd_pkg::FINE_RESET)
  ) u_fine (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_dac),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .q_o(fine_q)
  );

  ssd_field_reg #(
    .WIDTH(ssd_pkg::COARSE_W),
    .LSB(ssd_pkg::COARSE_LSB),
    .RESET(ssd_pkg::COARSE_RESET)
  ) u_coarse (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_dac),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .q_o(coarse_q)
  );

  ssd_field_reg #(
    .WIDTH(1),
    .LSB(ssd_pkg::ZERO_SEL_BIT),
    .RESET(ssd_pkg::SEL_RESET)
  ) u_zero_sel (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_ctl),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .q_o(zero_sel_q)
  );

  ssd_field_reg #(
    .WIDTH(1),
    .LSB(ssd_pkg::SRC_SEL_BIT),
    .RESET(ssd_pkg::SEL_RESET)
  ) u_src_sel (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_ctl),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .q_o(src_sel_q)
  );

  // analog-side controls, one register stage so pins never glitch
  logic next_amp_bias;
  logic next_pot_bias;
  logic next_feedback;
  logic [ssd_pkg::BANK_W-1:0] next_bank;
  logic [ssd_pkg::COARSE_W-1:0] next_coarse;
  logic [ssd_pkg::FINE_W-1:0] next_fine;
  logic [ssd_pkg::FINE_W-1:0] next_zero_code;
  logic next_zero_sel;

  always_comb
  begin
    next_amp_bias = sw_q[ssd_pkg::AMP_BIAS_BIT];
    next_pot_bias = sw_q[ssd_pkg::POT_BIAS_BIT];
    next_feedback = sw_q[ssd_pkg::FEEDBACK_BIT];
    next_bank = sw_q[ssd_pkg::SW_LSB +: ssd_pkg::BANK_W];
    // wavegen codes assumed on this clock, so no synchroniser
    if (src_sel_q[0])
    begin
      next_coarse = wave_coarse_i;
      next_fine = wave_fine_i;
    end
    else
    begin
      next_coarse = coarse_q;
      next_fine = fine_q;
    end
    next_zero_sel = zero_sel_q[0];
    if (zero_sel_q[0])
      next_zero_code = next_fine;
    else
      next_zero_code = {ssd_pkg::ZPAD, next_coarse};
    if (rst_i)
    begin
      next_amp_bias = 1'b0;
      next_pot_bias = 1'b0;
      next_feedback = 1'b0;
      next_bank = ssd_pkg::SW_RESET[ssd_pkg::BANK_W-1:0];
      next_coarse = ssd_pkg::COARSE_RESET;
      next_fine = ssd_pkg::FINE_RESET;
      next_zero_code = ssd_pkg::FINE_RESET;
      next_zero_sel = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    amp_bias_to_zero_pin_o <= next_amp_bias;
    pot_bias_to_bias_pin_o <= next_pot_bias;
    feedback_element_switch_o <= next_feedback;
    switch_bank_o <= next_bank;
    coarse_code_o <= next_coarse;
    fine_code_o <= next_fine;
    zero_reference_code_o <= next_zero_code;
    zero_node_width_select_o <= next_zero_sel;
  end

endmodule

// ==== ssd_regs_monitor.sv ====
`timescale 1ns/100ps
module ssd_regs_monitor #(
  parameter int unsigned ADDR_W = 32
) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic [ADDR_W-1:0] adr_i, // address
  input wire logic [31:0] dat_i, // write data
  input wire logic [31:0] dat_o, // read data
  input wire logic we_i, // write
  input wire logic [3:0] sel_i, // lanes
  input wire logic ack_o, // ack
  input wire logic err_o, // error
  input wire logic amp_bias_to_zero_pin_o, // bit 13
  input wire logic pot_bias_to_bias_pin_o, // bit 12
  input wire logic feedback_element_switch_o, // bit 5
  input wire logic [11:0] switch_bank_o, // bits 11..0
  input wire logic [5:0] coarse_code_o, // coarse
  input wire logic [11:0] fine_code_o, // fine
  input wire logic [11:0] zero_reference_code_o, // zero node
  input wire logic zero_node_width_select_o // width select
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic sw_hit;
  logic dac_hit;
  assign sw_hit = adr_i[31:2] == ssd_pkg::CH_SWITCH_ADDR[31:2];
  assign dac_hit = adr_i[31:2] == ssd_pkg::DAC_CODES_ADDR[31:2];
  // outputs land one edge after the ack edge
  sequence s_sw_wr;
    ack_o && we_i && sw_hit && sel_i[1];
  endsequence
  a_amp_bias: assert property (s_sw_wr |=> ##1
    amp_bias_to_zero_pin_o == $past(dat_i[13], 2)) else $error("amp bias");
  a_pot_bias: assert property (s_sw_wr |=> ##1
    pot_bias_to_bias_pin_o == $past(dat_i[12], 2)) else $error("pot bias");
  a_bank_write: assert property (s_sw_wr ##0 sel_i[0] |=> ##1
    switch_bank_o == $past(dat_i[11:0], 2)) else $error("bank");
  a_fb_switch: assert property (ack_o && we_i && sw_hit && sel_i[0] |=> ##1
    feedback_element_switch_o == $past(dat_i[5], 2)) else $error("feedback");
  a_sw_resv: assert property (ack_o && !we_i && sw_hit |->
    dat_o[31:14] == '0) else $error("switch reserved");
  a_dac_resv: assert property (ack_o && !we_i && dac_hit |->
    dat_o[31:18] == '0) else $error("dac reserved");
  a_zero_fine: assert property (zero_node_width_select_o |->
    zero_reference_code_o == fine_code_o) else $error("zero fine");
  a_zero_coarse: assert property (!zero_node_width_select_o |->
    zero_reference_code_o == {6'h00, coarse_code_o}) else $error("zero crs");
  a_err_quiet: assert property (err_o |->
    dat_o == '0 && !ack_o) else $error("err data");
endmodule
bind ssd_regs ssd_regs_monitor #(.ADDR_W(ADDR_W)) i_ssd_regs_monitor (
  .clk_i(clk_i),
  .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i),
  .sel_i(sel_i), .ack_o(ack_o), .err_o(err_o),
  .amp_bias_to_zero_pin_o(amp_bias_to_zero_pin_o),
  .pot_bias_to_bias_pin_o(pot_bias_to_bias_pin_o),
  .feedback_element_switch_o(feedback_element_switch_o),
  .switch_bank_o(switch_bank_o), .coarse_code_o(coarse_code_o),
  .fine_code_o(fine_code_o), .zero_reference_code_o(zero_reference_code_o),
  .zero_node_width_select_o(zero_node_width_select_o));

// ==== ssd_regs_tb.sv ====
`timescale 1ns/100ps
module ssd_regs_tb;
  localparam logic [31:0] SW = ssd_pkg::CH_SWITCH_ADDR;
  localparam logic [31:0] DC = ssd_pkg::DAC_CODES_ADDR;
  localparam logic [31:0] CT = ssd_pkg::DAC_CTRL_ADDR;
  logic clk_i = 1'b0, rst_i = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic [31:0] adr = '0, dat = '0, r;
  logic [3:0] sel = '0;
  logic [5:0] wc = '0, coarse;
  logic [11:0] wf = '0, bank, fine, zr;
  logic [31:0] dat_o, q[$];
  logic ack_o, err_o, amp, pot, fb, zs;
  int miscompares = 0, cmp_count = 0;
  always #12.5 clk_i = ~clk_i;
  ssd_regs i_ssd_regs (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr),
    .dat_i(dat), .dat_o(dat_o), .we_i(we), .sel_i(sel), .cyc_i(cyc),
    .stb_i(stb), .ack_o(ack_o), .err_o(err_o), .wave_coarse_i(wc),
    .wave_fine_i(wf), .amp_bias_to_zero_pin_o(amp),
    .pot_bias_to_bias_pin_o(pot), .feedback_element_switch_o(fb),
    .switch_bank_o(bank), .coarse_code_o(coarse), .fine_code_o(fine),
    .zero_reference_code_o(zr), .zero_node_width_select_o(zs));
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wb(input logic [31:0] a, input logic w, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; adr <= a; we <= w; dat <= d; sel <= s;
    do @(posedge clk_i); while (!(ack_o || err_o));
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task rd(input logic [31:0] a, input logic [31:0] e);
    q.push_back(e);
    wb(a, 1'b0, '0, 4'hf);
  endtask
  // field outputs settle one edge after the ack edge
  task settle;
    @(posedge clk_i);
    #1;
  endtask
  always @(posedge clk_i)
    if ((ack_o || err_o) && cyc && !we)
      chk(dat_o, q.pop_front());
  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (4000) @(posedge clk_i);
    miscompares++;
    summarize();
  end
  initial
  begin
    void'($urandom(1));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(SW, '0);
    rd(DC, '0);
    rd(CT, '0);
    chk({zs, amp, pot, fb, bank}, '0);
    chk({coarse, fine, zr}, '0);
    $display("test reset done");
    repeat (8)
    begin
      r = $urandom;
      wb(SW, 1'b1, r, 4'hf);
      settle();
      chk({amp, pot, bank}, r[13:0]);
      chk(fb, r[5]);
      rd(SW, r & 32'h3fff);
      r = $urandom;
      wb(DC, 1'b1, r, 4'hf);
      settle();
      chk({coarse, fine}, r[17:0]);
      chk(zr, r[17:12]);
      rd(DC, r & 32'h3ffff);
    end
    $display("test random fields done");
    wb(CT, 1'b1, 32'h10, 4'hf);
    settle();
    chk({zs, zr}, {1'b1, r[11:0]});
    @(posedge clk_i);
    wc <= 6'($urandom);
    wf <= 12'($urandom);
    wb(CT, 1'b1, 32'hffffffff, 4'hf);
    settle();
    chk({coarse, fine, zr}, {wc, wf, wf});
    rd(CT, 32'h50);
    wb(CT, 1'b1, 32'h0, 4'hf);
    settle();
    chk({coarse, fine}, r[17:0]);
    $display("test selects done");
    wb(SW, 1'b1, 32'h0, 4'hf);
    wb(SW, 1'b1, 32'hffffffff, 4'h1);
    rd(SW, 32'hff);
    wb(SW, 1'b1, 32'hffffffff, 4'h2);
    rd(SW, 32'h3fff);
    wb(SW + 32'h4, 1'b1, 32'h0, 4'hf);
    rd(SW, 32'h3fff);
    rd(SW + 32'h4, '0);
    $display("test lanes and unmapped done");
    summarize();
  end
endmodule
